// ### logic/limit_compare.sv
// Per-input comparison of a conversion result against its two limits
`timescale 1ns/1ps
`default_nettype none

module limit_compare #(
  parameter int CHANNELS = 16,
  parameter int RESULT_W = 10
) (
  // Conversion result
  input wire logic i_sample_valid,
  input wire logic [3:0] i_sample_chan,
  input wire logic [RESULT_W-1:0] i_sample_data,
  // Limits
  input wire logic [RESULT_W-1:0] i_high_limit [CHANNELS],
  input wire logic [RESULT_W-1:0] i_low_limit [CHANNELS],
  // Trip events
  output logic [CHANNELS-1:0] o_over_set,
  output logic [CHANNELS-1:0] o_under_set
);

  if (CHANNELS > 16) begin : g_bad_channels
    $error("limit_compare: at most 16 channels fit a 4-bit selector");
  end

  // ----------------------------------------------------------------
  // One comparator pair per input
  // ----------------------------------------------------------------
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    logic hit;
    assign hit = i_sample_valid && (i_sample_chan == 4'(c));
    // A limit at full scale can never be exceeded, so the default is quiet
    assign o_over_set[c] = hit && (i_sample_data > i_high_limit[c]);
    assign o_under_set[c] = hit && (i_sample_data < i_low_limit[c]);
  end

endmodule

`default_nettype wire

// ### logic/monitor_status_mask_regs.sv
// Monitor register bank: output power control, results, status flags, masks, limits
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Writing 0 powers down that analog output
// - Power control bits all read-write, reset to one
// - Word after power control reads zero
// - On-chip temperature result, 10 bits, reset zero
// - Diode temperature result, 10 bits, reset zero
// - Over-limit flags for inputs in two registers
// - Under-limit flags for inputs in two registers
// - Limit flag read clears next read; over-limit read drops event pin
// - Diode open or short sets fault bit four
// - Temperature trip flags in bits three to zero
// - First mask: one blocks inputs 1-8 event
// - Second mask: one blocks inputs 9-16 event
// - Per-input high limit, default all ones
module monitor_status_mask_regs
  import monitor_regs_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int RESULT_W = 10
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register access from the serial engine
  input wire logic [monitor_regs_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [monitor_regs_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [monitor_regs_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Conversion results from the converter sequencer
  input wire logic i_sample_valid,
  input wire logic [3:0] i_sample_chan,
  input wire logic [RESULT_W-1:0] i_sample_data,
  input wire logic i_onchip_temp_valid,
  input wire logic [RESULT_W-1:0] i_onchip_temp_data,
  input wire logic i_diode_temp_valid,
  input wire logic [RESULT_W-1:0] i_diode_temp_data,
  // Temperature condition levels
  input wire logic i_diode_fault,
  input wire logic i_onchip_high_trip,
  input wire logic i_diode_high_trip,
  input wire logic i_onchip_low_trip,
  input wire logic i_diode_low_trip,
  // Outputs
  output logic [monitor_regs_pkg::NUM_OUTPUTS-1:0] o_analog_out_enable,
  output logic o_limit_event
);

  import monitor_regs_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Two 8-bit flag registers and two masks carry the inputs, so 16 is fixed
  if (CHANNELS != NUM_INPUTS) begin : g_bad_channels
    $error("monitor_status_mask_regs: CHANNELS must be 16");
  end
  if (RESULT_W != 10) begin : g_bad_result
    $error("monitor_status_mask_regs: RESULT_W must be 10");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] power_ctl;
  logic [15:0] next_power_ctl;
  logic [RESULT_W-1:0] onchip_temp;
  logic [RESULT_W-1:0] next_onchip_temp;
  logic [RESULT_W-1:0] diode_temp;
  logic [RESULT_W-1:0] next_diode_temp;
  logic [THERMAL_W-1:0] thermal;
  logic [THERMAL_W-1:0] next_thermal;
  logic [7:0] over_mask_lo;
  logic [7:0] next_over_mask_lo;
  logic [7:0] over_mask_hi;
  logic [7:0] next_over_mask_hi;
  logic [RESULT_W-1:0] high_limit [CHANNELS];
  logic [RESULT_W-1:0] next_high_limit [CHANNELS];
  logic [RESULT_W-1:0] low_limit [CHANNELS];
  logic [RESULT_W-1:0] next_low_limit [CHANNELS];
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic limit_event;
  logic next_limit_event;
  logic [CHANNELS-1:0] over_set;
  logic [CHANNELS-1:0] under_set;
  logic [CHANNELS-1:0] over_clear;
  logic [CHANNELS-1:0] under_clear;
  logic [CHANNELS-1:0] over_flags;
  logic [CHANNELS-1:0] under_flags;
  logic [CHANNELS-1:0] over_set_pending;
  logic in_high_range;
  logic in_low_range;
  logic [3:0] limit_index;
  logic [3:0] low_index;

  // ----------------------------------------------------------------
  // Limit window decode
  // ----------------------------------------------------------------
  always_comb begin
    in_high_range = (i_reg_addr >= HIGH_LIMIT_BASE) && (i_reg_addr < LOW_LIMIT_BASE);
    in_low_range = (i_reg_addr >= LOW_LIMIT_BASE) &&
                   (i_reg_addr < LOW_LIMIT_BASE + 8'(CHANNELS));
    limit_index = 4'(i_reg_addr - HIGH_LIMIT_BASE);
    low_index = 4'(i_reg_addr - LOW_LIMIT_BASE);
  end

  // ----------------------------------------------------------------
  // Output power control
  // ----------------------------------------------------------------
  always_comb begin
    next_power_ctl = power_ctl;
    if (i_reg_wr && (i_reg_addr == ANALOG_OUTPUT_POWER_CTL)) begin
      // Spare bits 15, 14, 7 and 6 keep whatever software writes
      next_power_ctl = i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      power_ctl <= POWER_CTL_RESET;
    end else begin
      power_ctl <= next_power_ctl;
    end
  end

  // A zero bit shuts its output down; two groups of six with a gap between
  assign o_analog_out_enable = {power_ctl[PWR_HI_LSB +: PWR_GROUP_W],
                                power_ctl[PWR_LO_LSB +: PWR_GROUP_W]};

  // ----------------------------------------------------------------
  // Temperature results and thermal flags
  // ----------------------------------------------------------------
  always_comb begin
    next_onchip_temp = onchip_temp;
    next_diode_temp = diode_temp;
    if (i_onchip_temp_valid) begin
      next_onchip_temp = i_onchip_temp_data;
    end
    if (i_diode_temp_valid) begin
      next_diode_temp = i_diode_temp_data;
    end
    next_thermal = '0;
    next_thermal[THERMAL_DIODE_FAULT_BIT] = i_diode_fault;
    next_thermal[THERMAL_ONCHIP_HIGH_BIT] = i_onchip_high_trip;
    next_thermal[THERMAL_DIODE_HIGH_BIT] = i_diode_high_trip;
    next_thermal[THERMAL_ONCHIP_LOW_BIT] = i_onchip_low_trip;
    next_thermal[THERMAL_DIODE_LOW_BIT] = i_diode_low_trip;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      onchip_temp <= RESULT_RESET;
      diode_temp <= RESULT_RESET;
      thermal <= '0;
    end else begin
      onchip_temp <= next_onchip_temp;
      diode_temp <= next_diode_temp;
      thermal <= next_thermal;
    end
  end

  // ----------------------------------------------------------------
  // Event masks
  // ----------------------------------------------------------------
  always_comb begin
    next_over_mask_lo = over_mask_lo;
    next_over_mask_hi = over_mask_hi;
    if (i_reg_wr && (i_reg_addr == INPUT_OVER_EVENT_MASK_LO)) begin
      next_over_mask_lo = i_reg_wdata[7:0];
    end
    if (i_reg_wr && (i_reg_addr == INPUT_OVER_EVENT_MASK_HI)) begin
      next_over_mask_hi = i_reg_wdata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      over_mask_lo <= MASK_RESET;
      over_mask_hi <= MASK_RESET;
    end else begin
      over_mask_lo <= next_over_mask_lo;
      over_mask_hi <= next_over_mask_hi;
    end
  end

  // ----------------------------------------------------------------
  // Limit memory
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_high_limit[c] = high_limit[c];
      next_low_limit[c] = low_limit[c];
    end
    if (i_reg_wr && in_high_range) begin
      next_high_limit[limit_index] = i_reg_wdata[RESULT_W-1:0];
    end
    if (i_reg_wr && in_low_range) begin
      next_low_limit[low_index] = i_reg_wdata[RESULT_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int c = 0; c < CHANNELS; c++) begin
        high_limit[c] <= HIGH_LIMIT_RESET;
        low_limit[c] <= LOW_LIMIT_RESET;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        high_limit[c] <= next_high_limit[c];
        low_limit[c] <= next_low_limit[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparison and status flags
  // ----------------------------------------------------------------
  limit_compare #(
    .CHANNELS(CHANNELS),
    .RESULT_W(RESULT_W)
  ) u_compare (
    .i_sample_valid(i_sample_valid),
    .i_sample_chan(i_sample_chan),
    .i_sample_data(i_sample_data),
    .i_high_limit(high_limit),
    .i_low_limit(low_limit),
    .o_over_set(over_set),
    .o_under_set(under_set)
  );

  // Reading an over or under flag word clears it; the read data is taken before the clear,
  // so the host sees the cleared word only on its next read
  always_comb begin
    over_clear = '0;
    under_clear = '0;
    if (i_reg_rd) begin
      if (i_reg_addr == INPUT_OVER_FLAGS_LO) begin
        over_clear[7:0] = 8'hFF;
      end
      if (i_reg_addr == INPUT_OVER_FLAGS_HI) begin
        over_clear[15:8] = 8'hFF;
      end
      if (i_reg_addr == INPUT_UNDER_FLAGS_LO) begin
        under_clear[7:0] = 8'hFF;
      end
      if (i_reg_addr == INPUT_UNDER_FLAGS_HI) begin
        under_clear[15:8] = 8'hFF;
      end
    end
  end

  sticky_flags #(
    .WIDTH(CHANNELS)
  ) u_over_flags (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_set(over_set),
    .i_clear(over_clear),
    .o_flags(over_flags)
  );

  sticky_flags #(
    .WIDTH(CHANNELS)
  ) u_under_flags (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_set(under_set),
    .i_clear(under_clear),
    .o_flags(under_flags)
  );

  // ----------------------------------------------------------------
  // Limit event pin
  // ----------------------------------------------------------------
  // Follows the flags' next state so it drops on the same edge as the clear;
  // under-limit flags have no mask in this bank and never raise the pin
  always_comb begin
    over_set_pending = ((over_flags & ~over_clear) | over_set) &
                       ~{over_mask_hi, over_mask_lo};
    next_limit_event = |over_set_pending;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      limit_event <= 1'b0;
    end else begin
      limit_event <= next_limit_event;
    end
  end

  assign o_limit_event = limit_event;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rvalid = i_reg_rd;
    next_rdata = READ_ZERO;
    if (i_reg_rd) begin
      if (in_high_range) begin
        next_rdata = {6'h00, high_limit[limit_index]};
      end else if (in_low_range) begin
        next_rdata = {6'h00, low_limit[low_index]};
      end else begin
        unique case (i_reg_addr)
          ANALOG_OUTPUT_POWER_CTL: begin
            next_rdata = power_ctl;
          end
          RESERVED_WORD: begin
            next_rdata = READ_ZERO;
          end
          ONCHIP_TEMP_RESULT: begin
            next_rdata = {6'h00, onchip_temp};
          end
          DIODE_TEMP_RESULT: begin
            next_rdata = {6'h00, diode_temp};
          end
          INPUT_OVER_FLAGS_LO: begin
            next_rdata = {8'h00, over_flags[7:0]};
          end
          INPUT_OVER_FLAGS_HI: begin
            next_rdata = {8'h00, over_flags[15:8]};
          end
          INPUT_UNDER_FLAGS_LO: begin
            next_rdata = {8'h00, under_flags[7:0]};
          end
          INPUT_UNDER_FLAGS_HI: begin
            next_rdata = {8'h00, under_flags[15:8]};
          end
          THERMAL_FAULT_FLAGS: begin
            next_rdata = {11'h000, thermal};
          end
          INPUT_OVER_EVENT_MASK_LO: begin
            next_rdata = {8'h00, over_mask_lo};
          end
          INPUT_OVER_EVENT_MASK_HI: begin
            next_rdata = {8'h00, over_mask_hi};
          end
          default: begin
            // Registers held elsewhere answer zero from this bank
            next_rdata = READ_ZERO;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata <= READ_ZERO;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;

endmodule

`default_nettype wire

// ### logic/sticky_flags.sv
// Sticky flag bank: hardware sets, a read clears, a set beats a clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Control
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clear,
  // Flags
  output logic [WIDTH-1:0] o_flags
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sticky_flags: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] flags;
  logic [WIDTH-1:0] next_flags;

  // ----------------------------------------------------------------
  // Set wins, so an event landing on the clearing read is kept
  // ----------------------------------------------------------------
  always_comb begin
    next_flags = (flags & ~i_clear) | i_set;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign o_flags = flags;

endmodule

`default_nettype wire

// ### pkg/monitor_regs_pkg.sv
// Register map constants for the monitor status and mask register bank
package monitor_regs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int RESULT_W = 10;
  localparam int NUM_INPUTS = 16;
  localparam int NUM_OUTPUTS = 12;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ANALOG_OUTPUT_POWER_CTL = 8'h0C;
  localparam logic [7:0] RESERVED_WORD = 8'h0D;
  localparam logic [7:0] ONCHIP_TEMP_RESULT = 8'h0E;
  localparam logic [7:0] DIODE_TEMP_RESULT = 8'h0F;
  localparam logic [7:0] INPUT_OVER_FLAGS_LO = 8'h10;
  localparam logic [7:0] INPUT_OVER_FLAGS_HI = 8'h11;
  localparam logic [7:0] INPUT_UNDER_FLAGS_LO = 8'h12;
  localparam logic [7:0] INPUT_UNDER_FLAGS_HI = 8'h13;
  localparam logic [7:0] THERMAL_FAULT_FLAGS = 8'h14;
  localparam logic [7:0] INPUT_OVER_EVENT_MASK_LO = 8'h15;
  localparam logic [7:0] INPUT_OVER_EVENT_MASK_HI = 8'h16;
  localparam logic [7:0] HIGH_LIMIT_BASE = 8'h36;
  localparam logic [7:0] LOW_LIMIT_BASE = 8'h46;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PWR_LO_LSB = 0;
  localparam int PWR_HI_LSB = 8;
  localparam int PWR_GROUP_W = 6;
  localparam int THERMAL_DIODE_FAULT_BIT = 4;
  localparam int THERMAL_ONCHIP_HIGH_BIT = 3;
  localparam int THERMAL_DIODE_HIGH_BIT = 2;
  localparam int THERMAL_ONCHIP_LOW_BIT = 1;
  localparam int THERMAL_DIODE_LOW_BIT = 0;
  localparam int THERMAL_W = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] POWER_CTL_RESET = 16'hFFFF;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [9:0] HIGH_LIMIT_RESET = 10'h3FF;
  localparam logic [9:0] LOW_LIMIT_RESET = 10'h000;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

endpackage

// ### verif/monitor_regs_sva.sv
// Checker for the register port, power mapping and limit event behaviour
`timescale 1ns/1ps
`default_nettype none
module monitor_regs_sva
  import monitor_regs_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [monitor_regs_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [monitor_regs_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic [monitor_regs_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // Condition inputs
  input wire logic i_sample_valid,
  input wire logic i_diode_fault,
  input wire logic i_onchip_high_trip,
  input wire logic i_diode_high_trip,
  input wire logic i_onchip_low_trip,
  input wire logic i_diode_low_trip,
  // Outputs
  input wire logic [monitor_regs_pkg::NUM_OUTPUTS-1:0] o_analog_out_enable,
  input wire logic o_limit_event
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence clear_read;
    i_reg_rd && !i_reg_wr && i_reg_addr inside {[8'h10:8'h13]} && !i_sample_valid;
  endsequence
  // The host leaves one idle cycle between requests, so pairs sit two edges apart
  sequence clear_read_twice;
    clear_read ##1 !i_sample_valid ##1 (clear_read and i_reg_addr == $past(i_reg_addr, 2));
  endsequence
  sequence ctl_write_then_read;
    i_reg_wr && !i_reg_rd && i_reg_addr == 8'h0C ##1 !i_reg_wr
      ##1 i_reg_rd && !i_reg_wr && i_reg_addr == 8'h0C;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered one cycle later");
  idle_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 16'h0000)
    else $error("read data without a read");
  reserved_zero_a: assert property (i_reg_rd && i_reg_addr == 8'h0D |=> o_reg_rdata == 16'h0000)
    else $error("reserved word not zero");
  result_upper_a: assert property (i_reg_rd &&
    i_reg_addr inside {8'h0E, 8'h0F, [8'h36:8'h55]} |=> o_reg_rdata[15:10] == 6'h00)
    else $error("result upper bits not zero");
  status_upper_a: assert property (i_reg_rd &&
    i_reg_addr inside {[8'h10:8'h16]} |=> o_reg_rdata[15:8] == 8'h00)
    else $error("status or mask upper bits not zero");
  thermal_map_a: assert property (i_reg_rd && i_reg_addr == 8'h14 |=>
    o_reg_rdata == {11'h000, $past({i_diode_fault, i_onchip_high_trip, i_diode_high_trip,
    i_onchip_low_trip, i_diode_low_trip}, 2)})
    else $error("thermal flags do not follow levels");
  clear_twice_a: assert property (clear_read_twice |=> o_reg_rdata == 16'h0000)
    else $error("second status read not cleared");
  ctl_readback_a: assert property (ctl_write_then_read |=> o_reg_rdata == $past(i_reg_wdata, 3))
    else $error("power control readback wrong");
  enable_map_a: assert property (!i_reg_wr ##1
    (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h0C)
    |=> o_reg_rdata[5:0] == o_analog_out_enable[5:0]
    && o_reg_rdata[13:8] == o_analog_out_enable[11:6])
    else $error("output enables differ from power control");
  // A mask write acts one edge late, so the pin moves two edges after it
  event_rise_a: assert property ($rose(o_limit_event) |->
    $past(i_sample_valid || i_reg_wr) || $past(i_reg_wr, 2))
    else $error("limit event rose without a cause");
  event_fall_a: assert property ($fell(o_limit_event) |->
    $past(i_reg_rd || i_reg_wr) || $past(i_reg_wr, 2))
    else $error("limit event fell without a read");
endmodule
`default_nettype wire

bind monitor_status_mask_regs monitor_regs_sva chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_sample_valid(i_sample_valid),
  .i_diode_fault(i_diode_fault), .i_onchip_high_trip(i_onchip_high_trip),
  .i_diode_high_trip(i_diode_high_trip), .i_onchip_low_trip(i_onchip_low_trip),
  .i_diode_low_trip(i_diode_low_trip), .o_analog_out_enable(o_analog_out_enable),
  .o_limit_event(o_limit_event));

// ### verif/reg_host.sv
// Host model issuing one-cycle register reads and writes
`timescale 1ns/1ps
`default_nettype none
module reg_host
  import monitor_regs_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Register port toward the bank
  output logic [monitor_regs_pkg::ADDR_W-1:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [monitor_regs_pkg::DATA_W-1:0] o_wdata,
  input wire logic [monitor_regs_pkg::DATA_W-1:0] i_rdata,
  input wire logic i_rvalid
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // Idle lines park at the inverse so a stale sample cannot pass
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // Limit flag words need a second read to show clearing
  task automatic get(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Testbench for the monitor register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import monitor_regs_pkg::*;
  logic clk, rst, smp_v, ot_v, dt_v;
  logic [3:0] smp_c;
  logic [9:0] smp_d, ot_d, dt_d;
  logic [4:0] lv;
  logic [7:0] addr;
  logic wr, rd, rvalid;
  logic [15:0] wdata, rdata;
  logic [11:0] en;
  logic evt;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] ra [13] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h15, 8'h16, 8'h36, 8'h46};
  logic [15:0] rv [13] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h00FF, 16'h03FF, 16'h0000};
  logic [15:0] pw [3] = '{16'h2A15, 16'hC0C0, 16'hFFFF};
  logic [15:0] pe [3] = '{16'h0A95, 16'h0000, 16'h0FFF};
  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  monitor_status_mask_regs dut (.i_sys_clk(clk), .i_reset(rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_sample_valid(smp_v), .i_sample_chan(smp_c),
    .i_sample_data(smp_d), .i_onchip_temp_valid(ot_v), .i_onchip_temp_data(ot_d),
    .i_diode_temp_valid(dt_v), .i_diode_temp_data(dt_d), .i_diode_fault(lv[4]),
    .i_onchip_high_trip(lv[3]), .i_diode_high_trip(lv[2]), .i_onchip_low_trip(lv[1]),
    .i_diode_low_trip(lv[0]), .o_analog_out_enable(en), .o_limit_event(evt));
  reg_host host (.i_sys_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.get(a, d, v);
    chk($sformatf("rvalid %h", a), 16'h0001, {15'h0000, v});
    chk($sformatf("reg %h", a), exp, d);
  endtask
  task automatic smp(input logic [3:0] c, input logic [9:0] d);
    @(posedge clk);
    #1;
    smp_c = c;
    smp_d = d;
    smp_v = 1'b1;
    @(posedge clk);
    #1;
    smp_v = 1'b0;
    smp_d = ~d;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {smp_v, ot_v, dt_v, lv, smp_c, smp_d, ot_d, dt_d} = '0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    for (int i = 0; i < 13; i++) rd_chk(ra[i], rv[i]);
    chk("out_enable", 16'h0FFF, {4'h0, en});
    $display("test reset_values done");
    for (int i = 0; i < 3; i++) begin
      host.put(ANALOG_OUTPUT_POWER_CTL, pw[i]);
      rd_chk(ANALOG_OUTPUT_POWER_CTL, pw[i]);
      chk("out_enable", pe[i], {4'h0, en});
    end
    host.put(RESERVED_WORD, 16'hFFFF);
    rd_chk(RESERVED_WORD, 16'h0000);
    rd_chk(8'h30, 16'h0000);
    $display("test power_control done");
    @(posedge clk);
    #1;
    {ot_v, dt_v, ot_d, dt_d} = {2'b11, 10'h2A5, 10'h3FF};
    @(posedge clk);
    #1;
    {ot_v, dt_v, ot_d, dt_d} = {2'b00, 10'h15A, 10'h000};
    host.put(ONCHIP_TEMP_RESULT, 16'hFFFF);
    rd_chk(ONCHIP_TEMP_RESULT, 16'h02A5);
    rd_chk(DIODE_TEMP_RESULT, 16'h03FF);
    $display("test temperature done");
    host.put(HIGH_LIMIT_BASE, 16'h0100);
    host.put(INPUT_OVER_EVENT_MASK_LO, 16'h00FE);
    smp(4'h0, 10'h101);
    chk("limit_event", 16'h0001, {15'h0000, evt});
    rd_chk(INPUT_OVER_FLAGS_LO, 16'h0001);
    chk("limit_event", 16'h0000, {15'h0000, evt});
    rd_chk(INPUT_OVER_FLAGS_LO, 16'h0000);
    smp(4'h9, 10'h3FF);
    rd_chk(INPUT_OVER_FLAGS_HI, 16'h0000);
    host.put(HIGH_LIMIT_BASE + 8'h09, 16'h0200);
    smp(4'h9, 10'h201);
    chk("limit_event", 16'h0000, {15'h0000, evt});
    host.put(INPUT_OVER_EVENT_MASK_HI, 16'h00FD);
    @(posedge clk);
    #1;
    chk("limit_event", 16'h0001, {15'h0000, evt});
    rd_chk(INPUT_OVER_FLAGS_HI, 16'h0002);
    chk("limit_event", 16'h0000, {15'h0000, evt});
    host.put(LOW_LIMIT_BASE, 16'h0010);
    smp(4'h0, 10'h00F);
    host.put(LOW_LIMIT_BASE + 8'h0F, 16'h0100);
    smp(4'hF, 10'h0FF);
    rd_chk(INPUT_UNDER_FLAGS_LO, 16'h0001);
    rd_chk(INPUT_UNDER_FLAGS_HI, 16'h0080);
    rd_chk(INPUT_UNDER_FLAGS_HI, 16'h0000);
    $display("test limit_flags done");
    for (int b = 0; b < 5; b++) begin
      @(posedge clk);
      #1;
      lv = 5'h01 << b;
      rd_chk(THERMAL_FAULT_FLAGS, 16'h0001 << b);
    end
    lv = 5'h00;
    $display("test thermal_flags done");
    close_out();
  end
endmodule
`default_nettype wire
